// ---- src/rtc_mon_cfg.svh ----
// register map, field positions and timing counts of the monitor block
`ifndef RTC_MON_CFG_SVH
`define RTC_MON_CFG_SVH

`define CTL_OFFSET          4'hE
`define STS_OFFSET          4'hF
`define CTL_RESET           8'h00

`define CTL_WEEKDAY_EN      7
`define CTL_DAILY_EN        6
`define CTL_HOUR_FMT        5
`define CTL_CLKEN_N         4
`define CTL_TEST            3
`define CTL_SEL_HI          2
`define CTL_SEL_LO          0

`define STS_DAILY_FLAG      0
`define STS_WEEKDAY_FLAG    1
`define STS_PERIODIC_FLAG   2
`define STS_CLKEN_N         3
`define STS_OSC_HALT        4
`define STS_SPARE           5
`define STS_LOW_SUPPLY      6
`define STS_THRESH_SEL      7

`define REF_PERIOD_NS       8
`define OSC_HZ              32768
`define OSC_PER_SEC         16'd32768
`define OSC_HALF_SEC        16'd16384
`define TRIM_PERIOD_S       20
`define TRIM_LAST_SEC       5'd19
`define SAMPLE_WIN_US       7800
`define SAMPLE_WIN_OSC      ((`SAMPLE_WIN_US * `OSC_HZ) / 1000000)
`define SEC_LAG_NS          92000
`define SEC_LAG_OSC         ((64'd92000 * 64'd32768) / 64'd1000000000)
`define HALT_TIMEOUT_NS     100000
`define HALT_TIMEOUT_CYC    (`HALT_TIMEOUT_NS / `REF_PERIOD_NS)

`endif

// ---- src/rtc_mon_pkg.sv ----
// types shared by the monitor block
package rtc_mon_pkg;

    typedef enum logic [2:0] {
        P_OFF,
        P_HELD_LOW,
        P_PULSE_2HZ,
        P_PULSE_1HZ,
        P_LEVEL_SEC,
        P_LEVEL_MIN,
        P_LEVEL_HOUR,
        P_LEVEL_MONTH
    } periodic_mode_t;

    typedef struct packed {
        logic [7:0]  ctl;
        logic        osc_halt;
        logic        low_supply;
        logic        thresh_sel;
        logic        clken_n_sts;
        logic        spare;
        logic        weekday_flag;
        logic        daily_flag;
        logic        periodic_flag;
        logic        weekday_irq;
        logic        daily_irq;
        logic        weekday_hit_prev;
        logic        daily_hit_prev;
        logic        osc_prev;
        logic [15:0] div;
        logic [4:0]  trim_sec;
        logic [2:0]  lag;
        logic        lag_run;
        logic        sec_inc;
        logic [15:0] halt_cnt;
        logic        irq_oe_n;
        logic        clk_oe_n;
        logic        sample_en;
        logic [7:0]  rdata;
    } state_t;

endpackage

// ---- src/sync2.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ---- src/rtc_monitor.sv ----
// halt sensing, supply monitor, alarms, periodic interrupt and clock gate
`timescale 1ns/10ps
`include "rtc_mon_cfg.svh"
module rtc_monitor #(
    parameter int   HALT_CYCLES = `HALT_TIMEOUT_CYC,
    parameter logic CLK_CTRL    = 1'b1
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       osc_clk,
    input  wire logic       ce,
    input  wire logic       supply_below_hi,
    input  wire logic       supply_below_lo,
    input  wire logic       reg_wr,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       sec_write,
    input  wire logic [2:0] cur_weekday,
    input  wire logic [5:0] cur_hour,
    input  wire logic [6:0] cur_minute,
    input  wire logic [6:0] alarm_w_days,
    input  wire logic [5:0] alarm_w_hour,
    input  wire logic [6:0] alarm_w_minute,
    input  wire logic [5:0] alarm_d_hour,
    input  wire logic [6:0] alarm_d_minute,
    input  wire logic       roll_minute,
    input  wire logic       roll_hour,
    input  wire logic       roll_month,
    input  wire logic [6:0] trim_value,
    output logic            sec_inc,
    output logic            supply_sample_en,
    output logic            osc_halt,
    output logic            hour_24,
    output logic            test_mode,
    output logic            irq_out_n,
    output logic            irq_out_n_oe_n,
    output logic            slow_clk_out,
    output logic            slow_clk_out_oe_n
);
    rtc_mon_pkg::state_t q;
    rtc_mon_pkg::state_t d;
    logic [3:0]          pins_s;
    logic                osc_s;
    logic                ce_s;
    logic                below_hi_s;
    logic                below_lo_s;

    sync2 #(
        .W (4)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({osc_clk, ce, supply_below_hi, supply_below_lo}),
        .sync_out (pins_s)
    );

    assign osc_s      = pins_s[3];
    assign ce_s       = pins_s[2];
    assign below_hi_s = pins_s[1];
    assign below_lo_s = pins_s[0];

    // decode of the three select bits
    function automatic rtc_mon_pkg::periodic_mode_t mode_of(
        input logic [2:0] sel
    );
        rtc_mon_pkg::periodic_mode_t m;
        case (sel)
            3'h0: m = rtc_mon_pkg::P_OFF;
            3'h1: m = rtc_mon_pkg::P_HELD_LOW;
            3'h2: m = rtc_mon_pkg::P_PULSE_2HZ;
            3'h3: m = rtc_mon_pkg::P_PULSE_1HZ;
            3'h4: m = rtc_mon_pkg::P_LEVEL_SEC;
            3'h5: m = rtc_mon_pkg::P_LEVEL_MIN;
            3'h6: m = rtc_mon_pkg::P_LEVEL_HOUR;
            default: m = rtc_mon_pkg::P_LEVEL_MONTH;
        endcase
        return m;
    endfunction

    // length of the current second in oscillator cycles
    function automatic logic [15:0] sec_len(
        input logic [6:0] trim,
        input logic       last
    );
        logic [15:0] len;
        len = `OSC_PER_SEC;
        if (last && !trim[6] && trim[5:1] != 5'h00)
            len = `OSC_PER_SEC - {8'h00, trim[5:0], 1'b0} + 16'h0002;
        else if (last && trim[6])
            len = `OSC_PER_SEC + {8'h00, ~trim[5:0] + 6'h01, 1'b0};
        return len;
    endfunction

    rtc_mon_pkg::periodic_mode_t mode;
    logic                        osc_rise;
    logic                        osc_edge;
    logic [15:0]                 term;
    logic                        weekday_hit;
    logic                        daily_hit;
    logic                        pulse_low;
    logic                        level_hit;
    logic                        below;
    logic                        wr_ctl;
    logic                        wr_sts;
    logic                        clk_run;

    always_comb
    begin
        d           = q;
        mode        = mode_of(q.ctl[`CTL_SEL_HI:`CTL_SEL_LO]);
        osc_rise    = osc_s && !q.osc_prev;
        osc_edge    = osc_s != q.osc_prev;
        term        = sec_len(trim_value, q.trim_sec == `TRIM_LAST_SEC);
        wr_ctl      = reg_wr && reg_addr == `CTL_OFFSET;
        wr_sts      = reg_wr && reg_addr == `STS_OFFSET;
        d.osc_prev  = osc_s;
        d.sec_inc   = 1'b0;

        // register writes; hardware sets below take priority
        if (wr_ctl)
            d.ctl = reg_wdata;
        if (wr_sts)
        begin
            d.thresh_sel  = reg_wdata[`STS_THRESH_SEL];
            d.spare       = reg_wdata[`STS_SPARE];
            d.clken_n_sts = reg_wdata[`STS_CLKEN_N];
            if (!reg_wdata[`STS_OSC_HALT])
                d.osc_halt = 1'b0;
            if (!reg_wdata[`STS_LOW_SUPPLY])
                d.low_supply = 1'b0;
            if (!reg_wdata[`STS_WEEKDAY_FLAG])
            begin
                d.weekday_flag = 1'b0;
                d.weekday_irq  = 1'b0;
            end
            if (!reg_wdata[`STS_DAILY_FLAG])
            begin
                d.daily_flag = 1'b0;
                d.daily_irq  = 1'b0;
            end
            if (!reg_wdata[`STS_PERIODIC_FLAG])
                d.periodic_flag = 1'b0;
        end

        if (osc_edge)
            d.halt_cnt = 16'h0000;
        else if (q.halt_cnt != 16'(HALT_CYCLES - 1))
            d.halt_cnt = q.halt_cnt + 16'h0001;
        if (!ce_s && !osc_edge && q.halt_cnt == 16'(HALT_CYCLES - 1))
            d.osc_halt = 1'b1;

        if (sec_write)
        begin
            d.div     = 16'h0000;
            d.lag     = 3'h0;
            d.lag_run = 1'b0;
        end
        else if (osc_rise)
        begin
            if (q.div >= term - 16'h0001)
            begin
                d.div     = 16'h0000;
                d.lag     = 3'h0;
                d.lag_run = 1'b1;
            end
            else
                d.div = q.div + 16'h0001;
            if (q.lag_run)
            begin
                if (q.lag == 3'(`SEC_LAG_OSC) - 3'h1)
                begin
                    d.lag_run = 1'b0;
                    d.sec_inc = 1'b1;
                    if (q.trim_sec == `TRIM_LAST_SEC)
                        d.trim_sec = 5'h00;
                    else
                        d.trim_sec = q.trim_sec + 5'h01;
                end
                d.lag = q.lag + 3'h1;
            end
        end

        weekday_hit = alarm_w_days[cur_weekday]
                      && alarm_w_hour == cur_hour
                      && alarm_w_minute == cur_minute;
        daily_hit   = alarm_d_hour == cur_hour
                      && alarm_d_minute == cur_minute;
        d.weekday_hit_prev = weekday_hit;
        d.daily_hit_prev   = daily_hit;
        // only a new match raises the output
        if (weekday_hit && !q.weekday_hit_prev)
        begin
            d.weekday_flag = 1'b1;
            if (q.ctl[`CTL_WEEKDAY_EN])
                d.weekday_irq = 1'b1;
        end
        if (daily_hit && !q.daily_hit_prev)
        begin
            d.daily_flag = 1'b1;
            if (q.ctl[`CTL_DAILY_EN])
                d.daily_irq = 1'b1;
        end
        if (!d.ctl[`CTL_WEEKDAY_EN])
            d.weekday_irq = 1'b0;
        if (!d.ctl[`CTL_DAILY_EN])
            d.daily_irq = 1'b0;

        case (mode)
            rtc_mon_pkg::P_LEVEL_SEC:   level_hit = 1'b1;
            rtc_mon_pkg::P_LEVEL_MIN:   level_hit = roll_minute;
            rtc_mon_pkg::P_LEVEL_HOUR:  level_hit = roll_hour;
            rtc_mon_pkg::P_LEVEL_MONTH: level_hit = roll_month;
            default:                    level_hit = 1'b0;
        endcase
        if (d.sec_inc && level_hit)
            d.periodic_flag = 1'b1;

        case (mode)
            rtc_mon_pkg::P_HELD_LOW:  pulse_low = 1'b1;
            rtc_mon_pkg::P_PULSE_2HZ: pulse_low = !d.div[13];
            rtc_mon_pkg::P_PULSE_1HZ:
                pulse_low = d.div < term - `OSC_HALF_SEC;
            default:                  pulse_low = 1'b0;
        endcase

        below = q.thresh_sel ? below_lo_s : below_hi_s;
        d.sample_en = !d.low_supply
                      && d.div < 16'(`SAMPLE_WIN_OSC);
        if (q.sample_en && !q.low_supply && below)
            d.low_supply = 1'b1;

        if (d.osc_halt)
        begin
            d.ctl           = `CTL_RESET;
            d.thresh_sel    = 1'b0;
            d.low_supply    = 1'b0;
            d.clken_n_sts   = 1'b0;
            d.spare         = 1'b0;
            d.weekday_flag  = 1'b0;
            d.daily_flag    = 1'b0;
            d.periodic_flag = 1'b0;
            d.weekday_irq   = 1'b0;
            d.daily_irq     = 1'b0;
            d.sample_en     = 1'b0;
            pulse_low       = 1'b0;
        end

        d.irq_oe_n = !(d.weekday_irq || d.daily_irq
                       || pulse_low || d.periodic_flag);

        clk_run = !CLK_CTRL
                  || !(d.ctl[`CTL_CLKEN_N] && d.clken_n_sts);
        d.clk_oe_n = !(clk_run && !osc_s);

        if (reg_addr == `CTL_OFFSET)
            d.rdata = q.ctl;
        else if (reg_addr == `STS_OFFSET)
            d.rdata = {q.thresh_sel, q.low_supply, q.spare, q.osc_halt,
                       q.clken_n_sts, q.periodic_flag, q.weekday_flag,
                       q.daily_flag};
        else
            d.rdata = 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            q          <= '0;
            q.osc_halt <= 1'b1;
            q.irq_oe_n <= 1'b1;
            q.clk_oe_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign reg_rdata         = q.rdata;
    assign sec_inc           = q.sec_inc;
    assign supply_sample_en  = q.sample_en;
    assign osc_halt          = q.osc_halt;
    assign hour_24           = q.ctl[`CTL_HOUR_FMT];
    assign test_mode         = q.ctl[`CTL_TEST];
    assign irq_out_n         = 1'b0;
    assign irq_out_n_oe_n    = q.irq_oe_n;
    assign slow_clk_out      = 1'b0;
    assign slow_clk_out_oe_n = q.clk_oe_n;
endmodule

// ---- bench/rtc_monitor_monitor.sv ----
// assertion checker bound to the monitor block
`timescale 1ns/10ps
module rtc_monitor_checker #(
    parameter int HALT_CYCLES = 12500
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       osc_clk,
    input wire logic       ce,
    input wire logic       reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       osc_halt,
    input wire logic       hour_24,
    input wire logic       test_mode,
    input wire logic       irq_out_n,
    input wire logic       irq_out_n_oe_n,
    input wire logic       slow_clk_out,
    input wire logic       slow_clk_out_oe_n
);
    logic [31:0] still_q;
    logic        osc_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // cycles without an oscillator edge while chip enable is low
    always_ff @(posedge ref_clk)
    begin
        osc_q <= osc_clk;
        if (!rst_n || ce || osc_clk != osc_q)
            still_q <= 32'h0;
        else
            still_q <= still_q + 32'h1;
    end

    property p_halt_pwr;
        $rose(rst_n) |-> osc_halt;
    endproperty
    a_halt_pwr: assert property (p_halt_pwr)
        else $error("halt flag low after reset");
    property p_halt_sticky;
        osc_halt && !(reg_wr && reg_addr == 4'hF && !reg_wdata[4])
            |=> osc_halt;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky)
        else $error("halt flag dropped without a clearing write");
    property p_halt_ce;
        $rose(osc_halt) |-> !$past(ce, 3);
    endproperty
    a_halt_ce: assert property (p_halt_ce)
        else $error("halt flag set while chip enable high");
    property p_halt_detect;
        still_q > HALT_CYCLES + 16 |-> osc_halt;
    endproperty
    a_halt_detect: assert property (p_halt_detect)
        else $error("stopped oscillator not flagged");
    property p_halt_forces;
        osc_halt [*3] |-> !hour_24 && !test_mode && irq_out_n_oe_n;
    endproperty
    a_halt_forces: assert property (p_halt_forces)
        else $error("configuration not cleared while halted");
    property p_open_drain;
        irq_out_n == 1'h0 && slow_clk_out == 1'h0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain data not low");
    property p_clk_follow;
        $fell(slow_clk_out_oe_n) && $past(rst_n, 3)
            |-> !$past(osc_clk, 3);
    endproperty
    a_clk_follow: assert property (p_clk_follow)
        else $error("clock output pulled low while oscillator high");
    property p_unmapped;
        reg_addr != 4'hE && reg_addr != 4'hF |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read nonzero");

    c_halt: cover property ($rose(osc_halt));
    c_irq: cover property ($fell(irq_out_n_oe_n));
    c_clk: cover property ($fell(slow_clk_out_oe_n));
endmodule

bind rtc_monitor rtc_monitor_checker #(
    .HALT_CYCLES(HALT_CYCLES)
) u_chk (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .osc_clk           (osc_clk),
    .ce                (ce),
    .reg_wr            (reg_wr),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .osc_halt          (osc_halt),
    .hour_24           (hour_24),
    .test_mode         (test_mode),
    .irq_out_n         (irq_out_n),
    .irq_out_n_oe_n    (irq_out_n_oe_n),
    .slow_clk_out      (slow_clk_out),
    .slow_clk_out_oe_n (slow_clk_out_oe_n)
);

// ---- bench/osc_model.sv ----
// slow crystal oscillator model feeding the monitor
`timescale 1ns/10ps
module osc_model (
    input  wire logic run,
    output logic      osc_clk
);
    // stands still low while stopped
    initial
    begin
        osc_clk = 1'h0;
        forever
        begin
            #80;
            osc_clk = run ? ~osc_clk : 1'h0;
        end
    end
endmodule

// ---- bench/rtc_monitor_bench.sv ----
// self-checking bench for the monitor block
`timescale 1ns/10ps
module rtc_monitor_bench;
    logic       ref_clk;
    logic       rst_n      = 1'h0;
    logic       osc_run    = 1'h1;
    logic       osc_clk;
    logic       ce         = 1'h0;
    logic       below_hi   = 1'h0;
    logic       below_lo   = 1'h0;
    logic       reg_wr     = 1'h0;
    logic [3:0] reg_addr   = 4'h0;
    logic [7:0] reg_wdata  = 8'h00;
    logic       sec_write  = 1'h0;
    logic [5:0] hr         = 6'h0A;
    logic [6:0] mn         = 7'h00;
    logic [6:0] trim       = 7'h00;
    logic       roll       = 1'h0;
    logic [7:0] reg_rdata;
    logic       sample_en;
    logic       osc_halt;
    logic       hour_24;
    logic       irq_oe_n;
    logic       clk_oe_n;
    int         fail_count = 0;
    int         n_compared = 0;
    int         i;
    int         k;

    osc_model u_osc (
        .run     (osc_run),
        .osc_clk (osc_clk)
    );

    rtc_monitor #(
        .HALT_CYCLES(100)
    ) u_dut (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .osc_clk           (osc_clk),
        .ce                (ce),
        .supply_below_hi   (below_hi),
        .supply_below_lo   (below_lo),
        .reg_wr            (reg_wr),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .sec_write         (sec_write),
        .cur_weekday       (3'h3),
        .cur_hour          (hr),
        .cur_minute        (mn),
        .alarm_w_days      (7'h08),
        .alarm_w_hour      (hr),
        .alarm_w_minute    (7'h15),
        .alarm_d_hour      (hr),
        .alarm_d_minute    (7'h14),
        .roll_minute       (roll),
        .roll_hour         (roll),
        .roll_month        (roll),
        .trim_value        (trim),
        .sec_inc           (),
        .supply_sample_en  (sample_en),
        .osc_halt          (osc_halt),
        .hour_24           (hour_24),
        .test_mode         (),
        .irq_out_n         (),
        .irq_out_n_oe_n    (irq_oe_n),
        .slow_clk_out      (),
        .slow_clk_out_oe_n (clk_oe_n)
    );

    initial
    begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        tick(1);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        tick(1);
        reg_addr = a;
        tick(2);
        check(reg_rdata, exp);
    endtask

    task automatic irq(input logic exp);
        tick(6);
        check(irq_oe_n, exp);
    endtask

    task automatic pulse_sec();
        tick(1);
        sec_write = 1'h1;
        tick(1);
        sec_write = 1'h0;
    endtask

    task automatic wait_for(input logic val, input logic halt);
        for (i = 0; i < 20000 && (halt ? osc_halt : sample_en) !== val; i++)
            tick(1);
        if (i == 20000)
        begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic clk_idle(input logic exp);
        for (i = 0; i < 60 && clk_oe_n === 1'h1; i++)
            tick(1);
        check(i == 60, exp);
    endtask

    initial
    begin
        tick(2);
        rst_n = 1'h1;
        rd(4'hF, 8'h10);
        rd(4'h3, 8'h00);
        wr(4'hF, 8'hFF);
        wr(4'hE, 8'hFF);
        rd(4'hF, 8'h10);
        rd(4'hE, 8'h00);
        wr(4'hF, 8'h00);
        rd(4'hF, 8'h00);
        wr(4'hE, 8'h10);
        wr(4'hF, 8'h08);
        clk_idle(1'h1);
        wr(4'hF, 8'h00);
        clk_idle(1'h0);
        wr(4'hE, 8'h01);
        irq(1'h0);
        wr(4'hE, 8'h00);
        irq(1'h1);
        for (k = 2; k < 8; k++)
        begin
            wr(4'hE, k[7:0]);
            pulse_sec();
            irq(k > 3);
            rd(4'hE, k[7:0]);
        end
        wr(4'hE, 8'h00);
        below_hi = 1'h1;
        wait_for(1'h1, 1'h0);
        tick(30);
        rd(4'hF, 8'h40);
        check(sample_en, 1'h0);
        wr(4'hF, 8'h40);
        rd(4'hF, 8'h40);
        wr(4'hF, 8'h80);
        pulse_sec();
        wait_for(1'h1, 1'h0);
        tick(30);
        rd(4'hF, 8'h80);
        wait_for(1'h0, 1'h0);
        below_lo = 1'h1;
        pulse_sec();
        wait_for(1'h1, 1'h0);
        tick(30);
        rd(4'hF, 8'hC0);
        below_lo = 1'h0;
        below_hi = 1'h0;
        mn = 7'h14;
        wr(4'hF, 8'h00);
        wr(4'hE, 8'h40);
        irq(1'h1);
        rd(4'hF, 8'h00);
        mn = 7'h15;
        irq(1'h1);
        rd(4'hF, 8'h02);
        mn = 7'h14;
        irq(1'h0);
        rd(4'hF, 8'h03);
        wr(4'hF, 8'h03);
        rd(4'hF, 8'h03);
        wr(4'hE, 8'hC0);
        mn = 7'h15;
        wr(4'hF, 8'h02);
        irq(1'h0);
        rd(4'hE, 8'hC0);
        wr(4'hF, 8'h00);
        irq(1'h1);
        wr(4'hE, 8'h20);
        check(hour_24, 1'h1);
        ce = 1'h1;
        osc_run = 1'h0;
        tick(300);
        check(osc_halt, 1'h0);
        ce = 1'h0;
        wait_for(1'h1, 1'h1);
        rd(4'hE, 8'h00);
        check(hour_24, 1'h0);
        osc_run = 1'h1;
        ce = 1'h1;
        tick(300);
        check(osc_halt, 1'h1);
        wr(4'hF, 8'h00);
        rd(4'hF, 8'h00);
        rst_n = 1'h0;
        tick(2);
        rst_n = 1'h1;
        rd(4'hF, 8'h10);
        finish_test();
    end
endmodule
